//--- dv/ext_pins.sv
`timescale 1ns/1ps
module ext_pins (
	output reg ext_clk,
	output reg gate
);
	initial begin
		ext_clk = 1'b0;
		gate = 1'b0;
	end
	// the pin only moves inside a burst and idles low between them
	task automatic pulse(input integer n);
		repeat (n) begin
			#23 ext_clk = 1'b1;
			#31 ext_clk = 1'b0;
		end
	endtask
endmodule

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
	reg         clk;
	reg         rst;
	reg  [7:0]  addr;
	reg  [31:0] wdata;
	reg         wr;
	reg         rd;
	reg         idle_mode;
	wire [31:0] rdata;
	wire        ext_clk;
	wire        gate;
	wire [15:0] timer_count;
	wire        period_match;
	wire        timer_running;
	integer     num_errors;
	integer     checks_done;
	integer     n;
	timer_a_control dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .idle_mode(idle_mode), .external_timer_clock_pin(ext_clk),
		.gate_pin(gate), .timer_count(timer_count), .period_match(period_match),
		.timer_running(timer_running));
	ext_pins pins (.ext_clk(ext_clk), .gate(gate));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string s, input [31:0] e, input [31:0] g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			num_errors = num_errors + 1;
			$display("wrong value %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic wr_reg(input [7:0] a, input [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input [7:0] a, output [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic rdc(input [7:0] a, input [31:0] e);
		logic [31:0] d;
		rd_reg(a, d);
		chk($sformatf("reg %h", a), e, d);
	endtask
	// counts gained over exactly 512 cycles, so any prescale phase gives a whole number
	task automatic run(input [31:0] c, input i, input g, input [15:0] e);
		logic [31:0] a;
		logic [31:0] b;
		idle_mode <= i;
		pins.gate <= g;
		wr_reg(8'h00, c);
		repeat (4) @(posedge clk);
		rd_reg(8'h10, a);
		repeat (510) @(posedge clk);
		rd_reg(8'h10, b);
		chk("ticks", {16'h0, e}, {16'h0, b[15:0] - a[15:0]});
		wr_reg(8'h04, 32'h8000);
	endtask
	task automatic ext(input [31:0] c, input integer p, input [15:0] e);
		logic [31:0] a;
		logic [31:0] b;
		wr_reg(8'h00, c);
		rd_reg(8'h10, a);
		pins.pulse(p);
		repeat (4) @(posedge clk);
		rd_reg(8'h10, b);
		chk("edges", {16'h0, e}, {16'h0, b[15:0] - a[15:0]});
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		num_errors = 0;
		checks_done = 0;
		rst = 1'b1;
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		idle_mode = 1'b0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdc(8'h00, 32'h0);
		rdc(8'h20, 32'hffff);
		wr_reg(8'h00, 32'hffffffff);
		rdc(8'h00, 32'hb0b6);
		rdc(8'h08, 32'h0);
		wr_reg(8'h04, 32'h8000);
		wr_reg(8'h0c, 32'h36);
		wr_reg(8'h08, 32'h4);
		rdc(8'h00, 32'h3084);
		wr_reg(8'h04, 32'hffffffff);
		run(32'h8000, 0, 0, 512);
		run(32'h8010, 0, 0, 64);
		run(32'h8020, 0, 0, 8);
		run(32'h8030, 0, 0, 2);
		run(32'ha000, 1, 0, 0);
		run(32'h8000, 1, 0, 512);
		run(32'h8080, 0, 1, 512);
		run(32'h8080, 0, 0, 0);
		run(32'h8002, 0, 0, 0);
		ext(32'h8086, 6, 6);
		wr_reg(8'h10, 32'h7);
		rdc(8'h00, 32'h8086);
		wr_reg(8'h00, 32'h9002);
		wr_reg(8'h10, 32'h1234);
		wr_reg(8'h10, 32'h55);
		rdc(8'h00, 32'h9802);
		pins.pulse(1);
		repeat (4) @(posedge clk);
		rdc(8'h00, 32'h9002);
		rdc(8'h10, 32'h1234);
		wr_reg(8'h00, 32'h8002);
		wr_reg(8'h10, 32'h1111);
		wr_reg(8'h10, 32'h2222);
		pins.pulse(1);
		repeat (4) @(posedge clk);
		rdc(8'h10, 32'h2222);
		wr_reg(8'h04, 32'hffffffff);
		wr_reg(8'h20, 32'h5);
		wr_reg(8'h10, 32'h0);
		wr_reg(8'h00, 32'h8000);
		n = 0;
		repeat (24) begin
			@(posedge clk);
			#1;
			if (period_match === 1'b1)
				n = n + 1;
		end
		chk("matches", 4, n);
		stop_test;
	end
	initial begin
		#200000;
		num_errors = num_errors + 1;
		stop_test;
	end
endmodule

//--- dv/timer_a_control_assertions.sv
`timescale 1ns/1ps
module timer_a_control_assertions (
	input wire        clk,
	input wire        rst,
	input wire [7:0]  addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire        idle_mode,
	input wire        external_timer_clock_pin,
	input wire        gate_pin,
	input wire [15:0] timer_count,
	input wire        period_match,
	input wire        timer_running
);
	reg armed;
	// a counter write may land late, so the step check skips the change after it
	always @(posedge clk)
		armed <= !rst && ((wr && addr[7:4] == 4'h1) || (armed && !$changed(timer_count)));
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence ctrl_rd;
		rd && addr == 8'h00 ##1 1'b1;
	endsequence
	rd_quiet_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data without read");
	unimpl_zero_a: assert property (ctrl_rd |-> (rdata & 32'hffff4749) == 32'h0)
		else $error("unimplemented bit set");
	pend_mode_a: assert property (ctrl_rd |-> !rdata[11] || (rdata[1] && !rdata[2]))
		else $error("pending in sync mode");
	run_state_a: assert property (ctrl_rd |-> timer_running ==
		(rdata[15] && !(rdata[13] && $past(idle_mode))))
		else $error("running state off");
	alias_zero_a: assert property ($past(rd && addr[3:0] != 4'h0) |-> rdata == 32'h0)
		else $error("alias read not zero");
	wrap_zero_a: assert property (period_match |-> timer_count == 16'h0)
		else $error("match without wrap");
	frozen_a: assert property ($changed(timer_count) && !$past(wr) |-> timer_running)
		else $error("count moved while stopped");
	step_one_a: assert property ($changed(timer_count) && !$past(wr) && !armed &&
		timer_count != 16'h0 |-> timer_count == $past(timer_count) + 16'h1)
		else $error("count step not one");
endmodule
bind timer_a_control timer_a_control_assertions props (.clk(clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .idle_mode(idle_mode),
	.external_timer_clock_pin(external_timer_clock_pin), .gate_pin(gate_pin),
	.timer_count(timer_count), .period_match(period_match), .timer_running(timer_running));

//--- rtl/timer_a_control.v
// Functional notes
// R1: bit 15 enables timer, resets zero
// R2: idle_stop halts timer during idle mode
// R3: write block ignores counter writes while pending
// R4: block clear allows back-to-back counter writes
// R5: pending bit set during asynchronous counter write
// R6: pending bit reads zero in synchronous mode
// R7: gate accumulation only with internal clock
// R8: prescale codes divide by 1/8/64/256
// R9: ext sync bit only matters externally
// R10: clock select: external pin or peripheral clock
// R11: unimplemented control bits read as zero
// R12: software avoids access right after disabling
// R13: clear, set, invert aliases at +4/+8/+c
// R14: count one per prescaled, optionally gated tick
// R15: wrap to zero at period, flag match
`timescale 1ns/1ps
`include "timer_a_map.vh"

module timer_a_control (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire        idle_mode,
	input  wire        external_timer_clock_pin,
	input  wire        gate_pin,
	output reg  [15:0] timer_count,
	output reg         period_match,
	output reg         timer_running
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg  [31:0] timer_control;
	reg  [15:0] timer_period;
	reg  [15:0] pending_value;
	reg         pending;
	reg  [31:0] next_control;
	reg  [15:0] next_count;
	reg  [15:0] next_period;
	reg  [31:0] read_value;
	reg  [31:0] count_alias;
	reg  [31:0] period_alias;

	wire [1:0]  alias_op   = addr[3:2];
	wire [7:0]  reg_base   = {addr[7:4], 4'h0};
	wire        word_ok    = (addr[1:0] == 2'b00);
	wire        hit_ctrl   = word_ok && (reg_base == `TA_OFS_CONTROL);
	wire        hit_count  = word_ok && (reg_base == `TA_OFS_COUNT);
	wire        hit_period = word_ok && (reg_base == `TA_OFS_PERIOD);

	wire        enable     = timer_control[`TA_BIT_ENABLE];
	wire        idle_stop  = timer_control[`TA_BIT_IDLE_STOP];
	wire        wr_block   = timer_control[`TA_BIT_WR_BLOCK];
	wire        gate_acc   = timer_control[`TA_BIT_GATE_ACC];
	wire [1:0]  presc_sel  = timer_control[`TA_BIT_PRESC_HI:`TA_BIT_PRESC_LO];
	wire        ext_sync   = timer_control[`TA_BIT_EXT_SYNC];
	wire        clk_sel    = timer_control[`TA_BIT_CLK_SEL];

	// unsynchronised external clock is the asynchronous timer mode
	wire        async_mode = clk_sel & ~ext_sync; // see R9

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	wire [1:0]  pin_level;
	wire [1:0]  pin_rise;

	timer_a_pin_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   ({gate_pin, external_timer_clock_pin}),
		.level (pin_level),
		.rise  (pin_rise)
	);

	wire        ext_edge   = pin_rise[0];
	wire        gate_level = pin_level[1];

	// ----------------------------------------
	// tick path
	// ----------------------------------------
	wire        run        = enable & ~(idle_stop & idle_mode); // see R1, R2
	wire        src_tick   = clk_sel ? ext_edge : 1'b1; // see R10
	wire        gate_ok    = (~clk_sel & gate_acc) ? gate_level : 1'b1; // see R7
	wire        presc_tick;

	timer_a_prescaler u_prescaler (
		.clk      (clk),
		.rst      (rst),
		.clear    (~enable),
		.select   (presc_sel),
		.tick_in  (run & src_tick & gate_ok), // see R14
		.tick_out (presc_tick)
	);

	// ----------------------------------------
	// alias write helper
	// ----------------------------------------
	function [31:0] alias_apply;
		input [1:0]  op;
		input [31:0] cur;
		input [31:0] wd;
		begin
			case (op)
				`TA_ALIAS_CLR: alias_apply = cur & ~wd; // see R13
				`TA_ALIAS_SET: alias_apply = cur | wd; // see R13
				`TA_ALIAS_INV: alias_apply = cur ^ wd; // see R13
				default:       alias_apply = wd;
			endcase
		end
	endfunction

	// ----------------------------------------
	// next register values
	// ----------------------------------------
	always @* begin
		next_control = timer_control;
		next_period  = timer_period;
		// aliases work on the full word; only the low half is stored
		count_alias  = alias_apply(alias_op, {16'h0000, timer_count}, wdata);
		period_alias = alias_apply(alias_op, {16'h0000, timer_period}, wdata);
		next_count   = count_alias[15:0];
		if (wr && hit_ctrl) begin
			next_control = alias_apply(alias_op, timer_control, wdata)
				& `TA_CTRL_WMASK; // see R11
		end
		if (wr && hit_period) begin
			next_period = period_alias[15:0];
		end
	end

	// ----------------------------------------
	// control and period registers
	// ----------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			timer_control <= `TA_CTRL_RESET;
			timer_period  <= `TA_PERIOD_RESET;
		end else begin
			timer_control <= next_control;
			timer_period  <= next_period;
		end
	end

	// ----------------------------------------
	// counter and asynchronous write path
	// ----------------------------------------
	// an asynchronous write lands on the next synchronised edge of the
	// external clock; if that clock stands still the write stays pending
	wire count_wr   = wr && hit_count;
	wire accept_wr  = count_wr && !(async_mode && wr_block && pending); // see R3, R4
	wire land_async = pending && (ext_edge || !async_mode);

	always @(posedge clk) begin
		if (rst) begin
			timer_count   <= `TA_COUNT_RESET;
			pending       <= 1'b0;
			pending_value <= `TA_COUNT_RESET;
			period_match  <= 1'b0;
		end else begin
			period_match <= 1'b0;
			if (accept_wr && async_mode) begin
				// a newer write replaces a pending one when not blocked
				pending       <= 1'b1; // see R4, R5
				pending_value <= next_count[15:0];
			end else if (land_async) begin
				pending <= 1'b0; // see R5
			end
			if (accept_wr && !async_mode) begin
				timer_count <= next_count[15:0];
			end else if (land_async) begin
				timer_count <= pending_value;
			end else if (presc_tick) begin
				if (timer_count == timer_period) begin
					timer_count  <= 16'h0000; // see R15
					period_match <= 1'b1; // see R15
				end else begin
					timer_count <= timer_count + 16'h0001; // see R14
				end
			end
		end
	end

	// ----------------------------------------
	// status output
	// ----------------------------------------
	// software should leave a gap after clearing enable; the flop delay
	// here makes the disabled state visible one cycle later (see R12)
	always @(posedge clk) begin
		if (rst) begin
			timer_running <= 1'b0;
		end else begin
			timer_running <= run;
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always @* begin
		read_value = 32'h00000000;
		if (alias_op == `TA_ALIAS_PLAIN) begin
			if (hit_ctrl) begin
				read_value = timer_control & `TA_CTRL_WMASK; // see R11
				read_value[`TA_BIT_WR_PENDING] = pending & async_mode; // see R5, R6
			end else if (hit_count) begin
				read_value = {16'h0000, timer_count};
			end else if (hit_period) begin
				read_value = {16'h0000, timer_period};
			end
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			rdata <= read_value;
		end else begin
			rdata <= 32'h00000000;
		end
	end

endmodule

//--- rtl/timer_a_map.vh
`ifndef TIMER_A_MAP_VH
`define TIMER_A_MAP_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TA_OFS_CONTROL     8'h00
`define TA_OFS_COUNT       8'h10
`define TA_OFS_PERIOD      8'h20

// ----------------------------------------
// alias offsets added to a register base
// ----------------------------------------
`define TA_ALIAS_PLAIN     2'h0
`define TA_ALIAS_CLR       2'h1
`define TA_ALIAS_SET       2'h2
`define TA_ALIAS_INV       2'h3

// ----------------------------------------
// control field positions
// ----------------------------------------
`define TA_BIT_ENABLE      15
`define TA_BIT_IDLE_STOP   13
`define TA_BIT_WR_BLOCK    12
`define TA_BIT_WR_PENDING  11
`define TA_BIT_GATE_ACC    7
`define TA_BIT_PRESC_HI    5
`define TA_BIT_PRESC_LO    4
`define TA_BIT_EXT_SYNC    2
`define TA_BIT_CLK_SEL     1

// ----------------------------------------
// writable bits and reset values
// ----------------------------------------
`define TA_CTRL_WMASK      32'h0000b0b6
`define TA_CTRL_RESET      32'h00000000
`define TA_COUNT_RESET     16'h0000
`define TA_PERIOD_RESET    16'hffff

// ----------------------------------------
// prescale codes and divide counts
// ----------------------------------------
`define TA_PRESC_1         2'h0
`define TA_PRESC_8         2'h1
`define TA_PRESC_64        2'h2
`define TA_PRESC_256       2'h3
`define TA_DIV_8_LAST      8'h07
`define TA_DIV_64_LAST     8'h3f
`define TA_DIV_256_LAST    8'hff

`endif

//--- rtl/timer_a_pin_sync.v
`timescale 1ns/1ps
`include "timer_a_map.vh"

module timer_a_pin_sync #(
	parameter WIDTH = 2
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] pin,
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] rise
);

	// ----------------------------------------
	// two-stage synchroniser plus edge history
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta;
			reg stable;
			reg prev;
			// the first stage feeds only the second stage
			always @(posedge clk) begin
				if (rst) begin
					meta   <= 1'b0;
					stable <= 1'b0;
					prev   <= 1'b0;
				end else begin
					meta   <= pin[i];
					stable <= meta;
					prev   <= stable;
				end
			end
			assign level[i] = stable;
			assign rise[i]  = stable & ~prev;
		end
	endgenerate

endmodule

//--- rtl/timer_a_prescaler.v
`timescale 1ns/1ps
`include "timer_a_map.vh"

module timer_a_prescaler (
	input  wire       clk,
	input  wire       rst,
	input  wire       clear,
	input  wire [1:0] select,
	input  wire       tick_in,
	output wire       tick_out
);

	reg  [7:0] count;
	reg  [7:0] last;

	// ----------------------------------------
	// divide selection
	// ----------------------------------------
	always @* begin
		case (select)
			`TA_PRESC_8:   last = `TA_DIV_8_LAST;
			`TA_PRESC_64:  last = `TA_DIV_64_LAST;
			`TA_PRESC_256: last = `TA_DIV_256_LAST;
			default:       last = 8'h00;
		endcase
	end

	assign tick_out = tick_in & (count >= last); // see R8

	// a shrinking ratio can leave count above last; >= avoids a full wrap
	always @(posedge clk) begin
		if (rst || clear) begin
			count <= 8'h00;
		end else if (tick_in) begin
			if (count >= last) begin
				count <= 8'h00;
			end else begin
				count <= count + 8'h01;
			end
		end
	end

endmodule
